// [logic/random_byte_pkg.sv]
// random byte generator: shared register map, field layout, timing constants
// assumes an 8-bit special function register bus with separate read and write strobes
package random_byte_pkg;

	// register addresses on the special function register bus
	localparam logic [7:0] control_addr       = 8'hD6;
	localparam logic [7:0] value_addr         = 8'hD7;

	// control register field positions and reset values
	localparam int         power_on_bit       = 7;
	localparam int         bias_fix_bit       = 6;
	localparam int         available_bit      = 5;
	localparam logic [7:0] control_reset      = 8'h40;
	localparam logic [7:0] value_reset        = 8'h00;

	// timing figures in their own units
	localparam int         clock_mhz          = 200;
	localparam int         startup_delay_ns   = 250000;
	localparam int         byte_period_ns     = 100000;
	// shortest time per byte keeps the rate at or below ten kilobytes per second
	localparam int         startup_cycles     = (startup_delay_ns * clock_mhz + 999) / 1000;
	localparam int         byte_cycles        = (byte_period_ns * clock_mhz + 999) / 1000;
	localparam int         bits_per_byte      = 8;

	// bus request carrier
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_request_type;

	// bias corrector output carrier
	typedef struct packed {
		logic valid;
		logic bit_value;
	} corrected_bit_type;

endpackage

// [logic/bias_corrector.sv]
// pair-wise bias corrector between the noise bit stream and the byte packer
// assumes noise bits arrive already synchronised, one per valid strobe
`timescale 1ns/1ps
`default_nettype none

module bias_corrector
(
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic                                enable,
	input  wire logic                                bypass,
	input  wire logic                                noise_bit,
	input  wire logic                                noise_valid,
	output var random_byte_pkg::corrected_bit_type   out_bit
);

	logic first_held;
	logic first_value;

	////////////////////////////////////////////////////////////////////////
	// pair tracking; cleared whenever idle so pairs never span sessions
	// all pairs, equal or not
	always_ff @(posedge clk)
	begin
		if (!rst_n || !enable || bypass)
			first_held <= 1'b0;
		else if (noise_valid)
			first_held <= !first_held;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			first_value <= 1'b0;
		else if (noise_valid && !first_held)
			first_value <= noise_bit;
	end

	////////////////////////////////////////////////////////////////////////
	// corrector or raw
	always_ff @(posedge clk)
	begin
		if (!rst_n || !enable)
			out_bit <= '0;
		else if (bypass)
			out_bit <= '{valid: noise_valid, bit_value: noise_bit};
		else
			// equal pairs are discarded; unequal emit the first bit
			out_bit <= '{valid: noise_valid && first_held && (first_value != noise_bit),
				bit_value: first_value};
	end

endmodule

`default_nettype wire

// [logic/random_byte_generator.sv]
// random byte generator: control register, byte packer, pacing and event output
// assumes noise source pins are asynchronous and the bus strobes are on clk
// read data is registered: it stands for one cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
`default_nettype none

module random_byte_generator
#(
	parameter int startup_count = random_byte_pkg::startup_cycles,
	parameter int pace_count    = random_byte_pkg::byte_cycles
)
(
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire random_byte_pkg::bus_request_type  bus_req,
	output logic [7:0]                             bus_rdata,
	input  wire logic                              noise_bit_pin,
	input  wire logic                              noise_valid_pin,
	output logic                                   random_byte_event
);

	// both counters are this wide; larger counts are rejected at elaboration
	localparam int count_width = 24;
	localparam int count_limit = (1 << count_width) - 1;

	// elaboration-time checks on the counts
	if (startup_count < 1 || startup_count > count_limit)
	begin : bad_startup
		$error("startup count out of range");
	end

	if (pace_count < 1 || pace_count > count_limit)
	begin : bad_pace
		$error("pace count out of range");
	end

	// sequencer states: powered down, start-up wait, collecting bits
	typedef enum logic [1:0] {idle_st, warmup_st, collect_st} gen_state_type;

	gen_state_type state;
	logic          generator_power_on;
	logic          bias_fix_enable;
	logic          byte_available;
	logic [7:0]    random_value;
	logic [7:0]    shift_reg;
	logic [2:0]    bit_count;
	logic [23:0]   wait_count;
	logic [23:0]   pace_timer;
	logic          power_prev;
	logic [1:0]    noise_bit_sync;
	logic [1:0]    noise_valid_sync;
	logic          valid_prev;
	logic          noise_strobe;
	logic          power_rise;
	logic          byte_done;
	logic          control_write;
	logic          control_read;
	logic          value_read;
	random_byte_pkg::corrected_bit_type packed_bit;

	localparam logic [23:0] startup_load = 24'(startup_count);
	localparam logic [23:0] pace_load    = 24'(pace_count);

	////////////////////////////////////////////////////////////////////////
	// true when a bus access targets the given register
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
		hits = (addr == target);
	endfunction

	// one step of a down counter that parks at zero instead of wrapping
	function automatic logic [23:0] count_down(input logic [23:0] value);
		if (value == 24'h000000)
			count_down = 24'h000000;
		else
			count_down = value - 24'h000001;
	endfunction

	// one new bit enters at the bottom, so the first bit of a byte ends in bit 7
	function automatic logic [7:0] shift_in(input logic [7:0] held, input logic new_bit);
		shift_in = {held[6:0], new_bit};
	endfunction

	// control byte built from the field positions; unused bits read as zero
	function automatic logic [7:0] control_image(input logic power, input logic fix, input logic avail);
		control_image                                 = 8'h00;
		control_image[random_byte_pkg::power_on_bit]  = power;
		control_image[random_byte_pkg::bias_fix_bit]  = fix;
		control_image[random_byte_pkg::available_bit] = avail;
	endfunction

	// shared set and clear decision, so the flag and the event cannot drift apart
	function automatic logic flag_update(input logic current, input logic wipe, input logic set, input logic take);
		if (wipe)
			flag_update = 1'b0;
		else if (set)
			flag_update = 1'b1;
		else if (take)
			flag_update = 1'b0;
		else
			flag_update = current;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// noise pins come from the analogue side, two flops before any use
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			noise_bit_sync   <= 2'h0;
			noise_valid_sync <= 2'h0;
		end
		else
		begin
			noise_bit_sync   <= {noise_bit_sync[0], noise_bit_pin};
			noise_valid_sync <= {noise_valid_sync[0], noise_valid_pin};
		end
	end

	// strobe edge detector; resets to the idle low level so no false edge follows reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			valid_prev <= 1'b0;
		else
			valid_prev <= noise_valid_sync[1];
	end

	assign noise_strobe  = noise_valid_sync[1] && !valid_prev && (state == collect_st);
	assign control_write = bus_req.write && hits(bus_req.addr, random_byte_pkg::control_addr);
	assign control_read  = bus_req.read && hits(bus_req.addr, random_byte_pkg::control_addr);
	assign value_read    = bus_req.read && hits(bus_req.addr, random_byte_pkg::value_addr);
	assign power_rise    = generator_power_on && !power_prev;

	bias_corrector u_corrector
	(
		.clk         (clk),
		.rst_n       (rst_n),
		.enable      (state == collect_st),
		.bypass      (!bias_fix_enable),
		.noise_bit   (noise_bit_sync[1]),
		.noise_valid (noise_strobe),
		.out_bit     (packed_bit)
	);

	////////////////////////////////////////////////////////////////////////
	// control bits writable, status read-only
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			generator_power_on <= random_byte_pkg::control_reset[random_byte_pkg::power_on_bit];
			bias_fix_enable    <= random_byte_pkg::control_reset[random_byte_pkg::bias_fix_bit];
		end
		else if (control_write)
		begin
			generator_power_on <= bus_req.wdata[random_byte_pkg::power_on_bit];
			bias_fix_enable    <= bus_req.wdata[random_byte_pkg::bias_fix_bit];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			power_prev <= 1'b0;
		else
			power_prev <= generator_power_on;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer; no standby input, so it runs regardless
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state      <= idle_st;
			wait_count <= 24'h000000;
		end
		else if (!generator_power_on)
			state <= idle_st;
		else if (power_rise)
		begin
			state      <= warmup_st;
			wait_count <= startup_load;
		end
		else
		begin
			case (state)
				warmup_st:
					if (wait_count <= 24'h000001)
						state <= collect_st;
					else
						wait_count <= count_down(wait_count);
				collect_st:
					state <= collect_st;
				idle_st:
					state <= idle_st;
				default:
					state <= idle_st;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial shift into holding register
	always_ff @(posedge clk)
	begin
		if (!rst_n || state != collect_st)
		begin
			shift_reg <= 8'h00;
			bit_count <= 3'h0;
		end
		else if (packed_bit.valid)
		begin
			shift_reg <= shift_in(shift_reg, packed_bit.bit_value);
			bit_count <= bit_count + 3'h1;
		end
	end

	// pacing; corrector yields at most one bit per pair, source rate sets the average
	always_ff @(posedge clk)
	begin
		if (!rst_n || state != collect_st)
			pace_timer <= 24'h000000;
		else if (byte_done)
			pace_timer <= pace_load;
		else
			pace_timer <= count_down(pace_timer);
	end

	// a byte finishing inside the pacing window is dropped; the bit count wraps and shifting goes on
	assign byte_done = packed_bit.valid && (bit_count == 3'(random_byte_pkg::bits_per_byte - 1))
		&& (pace_timer == 24'h000000) && (state == collect_st);

	////////////////////////////////////////////////////////////////////////
	// data register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			random_value <= random_byte_pkg::value_reset;
		else if (power_rise)
			random_value <= random_byte_pkg::value_reset;
		else if (byte_done)
			random_value <= shift_in(shift_reg, packed_bit.bit_value);
	end

	// set wins over the read clear
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			byte_available <= random_byte_pkg::control_reset[random_byte_pkg::available_bit];
		else
			byte_available <= flag_update(byte_available, power_rise, byte_done, value_read);
	end

	// event mirrors the flag, same set and clear conditions
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			random_byte_event <= 1'b0;
		else
			random_byte_event <= flag_update(random_byte_event, power_rise, byte_done, value_read);
	end

	////////////////////////////////////////////////////////////////////////
	// registered read data; contents meaningless while powered down
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bus_rdata <= 8'h00;
		else if (control_read)
			bus_rdata <= control_image(generator_power_on, bias_fix_enable, byte_available);
		else if (value_read)
			bus_rdata <= random_value;
		else
			bus_rdata <= 8'h00;
	end

endmodule

`default_nettype wire

// [tb/random_byte_sva.sv]
// checker: bus and event relations at the generator ports
// assumes one clk domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module random_byte_sva
#(
	parameter int startup_count = 4,
	parameter int pace_count    = 4
)
(
	input wire logic                             clk,
	input wire logic                             rst_n,
	input wire random_byte_pkg::bus_request_type bus_req,
	input wire logic [7:0]                       bus_rdata,
	input wire logic                             noise_bit_pin,
	input wire logic                             noise_valid_pin,
	input wire logic                             random_byte_event
);
	wire logic  wr_ctl = bus_req.write && bus_req.addr == random_byte_pkg::control_addr;
	wire logic  rd_dat = bus_req.read && bus_req.addr == random_byte_pkg::value_addr;
	logic       power_q;
	logic       fix_q;
	logic [3:0] quiet;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence rd_ctl;
		bus_req.read && bus_req.addr == random_byte_pkg::control_addr;
	endsequence
	////////////////////////////////////////
	// shadow of the writable control bits
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			{power_q, fix_q} <= 2'h1;
		else if (wr_ctl)
			{power_q, fix_q} <= bus_req.wdata[7:6];
	end
	// cycles since the last strobe; a set can only trail a strobe by a few cycles
	always_ff @(posedge clk)
	begin
		if (!rst_n || noise_valid_pin)
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	end
	////////////////////////////////////////
	chk_reset_out: assert property ($rose(rst_n) |-> bus_rdata == 8'h00 && !random_byte_event)
		else $error("outputs not clear after reset");
	chk_read_idle: assert property (!$past(bus_req.read) |-> bus_rdata == 8'h00)
		else $error("read data not idle");
	chk_unused_bits: assert property (rd_ctl |=> bus_rdata[4:0] == 5'h00)
		else $error("unused control bits set");
	chk_ctl_readback: assert property (rd_ctl |=> bus_rdata[7:6] == {power_q, fix_q})
		else $error("control bits lost");
	chk_flag_irq: assert property (rd_ctl |=> bus_rdata[5] == $past(random_byte_event))
		else $error("flag and event differ");
	chk_read_clear: assert property (rd_dat && quiet > 4'h9 |=> !random_byte_event)
		else $error("event kept after data read");
	chk_fall_cause: assert property ($fell(random_byte_event) |-> $past(rd_dat) || $past(wr_ctl, 2))
		else $error("event fell without cause");
	chk_rise_cause: assert property ($rose(random_byte_event) |-> power_q && quiet < 4'hA)
		else $error("event rose without noise");
	chk_power_clear: assert property (wr_ctl && bus_req.wdata[7] && !power_q |-> ##2 !random_byte_event [*4])
		else $error("power on kept event");
endmodule
bind random_byte_generator random_byte_sva #(.startup_count(startup_count), .pace_count(pace_count)) chk_u
	(.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .noise_bit_pin(noise_bit_pin),
	.noise_valid_pin(noise_valid_pin), .random_byte_event(random_byte_event));
`default_nettype wire

// [tb/noise_source.sv]
// noise source stand-in: one strobed bit per send_bit call
// assumes calls come one after another from a single process
`timescale 1ns/1ps
`default_nettype none
module noise_source
(
	input  wire logic clk,
	output logic      noise_bit,
	output logic      noise_valid
);
	initial
	begin
		noise_bit = 1'b0;
		noise_valid = 1'b0;
	end
	// bit with strobe
	// bit held across the strobe, then inverted so a stale level never looks valid
	task automatic send_bit(input logic b);
		@(posedge clk);
		noise_bit <= b;
		noise_valid <= 1'b1;
		repeat (3) @(posedge clk);
		noise_valid <= 1'b0;
		repeat (3) @(posedge clk);
		noise_bit <= ~b;
	endtask
endmodule
`default_nettype wire

// [tb/true_random_byte_generator_bench.sv]
// self-checking bench for the random byte generator
// assumes short warm-up and pace counts so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module true_random_byte_generator_bench;
	logic                             clk = 1'b0;
	logic                             rst_n = 1'b0;
	random_byte_pkg::bus_request_type bus_req = '0;
	logic [7:0]                       bus_rdata;
	logic                             noise_bit;
	logic                             noise_valid;
	logic                             random_byte_event;
	logic [7:0]                       expect_q[$];
	logic                             rd_seen = 1'b0;
	int                               err_count = 0;
	int                               comparisons = 0;
	logic [31:0]                      seed = 32'h00002F9B;
	logic [7:0]                       v;
	always #2.5 clk = ~clk;
	random_byte_generator #(.startup_count(4), .pace_count(4)) dut_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .noise_bit_pin(noise_bit), .noise_valid_pin(noise_valid),
		.random_byte_event(random_byte_event));
	noise_source src_u (.clk(clk), .noise_bit(noise_bit), .noise_valid(noise_valid));
	////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check_val(input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask
	task automatic check_bit(input logic exp);
		check_val({7'h00, exp}, {7'h00, random_byte_event});
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{write: w, read: r, addr: a, wdata: d};
		@(posedge clk);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		expect_q.push_back(exp);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	// event comes at an unknown time; extra cycles let a trailing byte land
	task automatic wait_event;
		for (int n = 0; n < 200 && random_byte_event !== 1'b1; n++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		check_bit(1'b1);
	endtask
	// first bit ends in bit 7; with the fixer on, equal pairs vanish
	task automatic send_byte(input logic fix, output logic [7:0] b);
		for (int k = 0; k < 8;)
		begin
			seed = xorshift(seed);
			src_u.send_bit(seed[0]);
			if (fix)
				src_u.send_bit(seed[1]);
			if (!fix || seed[0] != seed[1])
			begin
				b = {b[6:0], seed[0]};
				k++;
			end
		end
	endtask
	////////////////////////////////////////
	// read data shows one cycle after each read strobe
	always @(posedge clk)
	begin
		if (rd_seen)
			check_val(expect_q.pop_front(), bus_rdata);
		rd_seen = bus_req.read;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			rd(8'hD6, 8'h40);
			rd(8'hD7, 8'h00);
			rd(8'hD5, 8'h00);
			bus(1'b1, 1'b0, 8'hD7, 8'hFF);
			rd(8'hD7, 8'h00);
			bus(1'b1, 1'b0, 8'hD6, 8'hBF);
			rd(8'hD6, 8'h80);
			repeat (10) @(posedge clk);
			send_byte(1'b0, v);
			wait_event();
			rd(8'hD6, 8'hA0);
			rd(8'hD7, v);
			#1 check_bit(1'b0);
			send_byte(1'b0, v);
			send_byte(1'b0, v);
			wait_event();
			rd(8'hD7, v);
			send_byte(1'b0, v);
			wait_event();
			bus(1'b1, 1'b0, 8'hD6, 8'h00);
			bus(1'b1, 1'b0, 8'hD6, 8'hC0);
			rd(8'hD6, 8'hC0);
			rd(8'hD7, 8'h00);
			repeat (10) @(posedge clk);
			send_byte(1'b1, v);
			wait_event();
			rd(8'hD7, v);
			rst_n <= 1'b0;
			repeat (4) @(posedge clk);
			rst_n <= 1'b1;
		end
		complete_run();
	end
	initial
	begin
		#400000;
		err_count++;
		complete_run();
	end
	task automatic complete_run;
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
endmodule
`default_nettype wire
